// ---- hw/bcd_convert.sv ----
// free running binary to bcd converter with tag passed alongside
`default_nettype none
module bcd_convert
	import bcd_port_pkg::*;
(
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// value in
	input  wire logic [MAG_W-1:0] bin,
	input  wire logic [TAG_W-1:0] tag,
	// result out
	output logic      [BCD_W-1:0] bcd,
	output logic      [TAG_W-1:0] tag_out
);
	conv_state_s q;
	conv_state_s d;
	logic [BCD_W-1:0] adj;

	// ======================================================
	// add three per digit
	for (genvar g = 0; g < DIGITS; g++) begin : g_adj
		assign adj[4*g +: 4] = (q.sh[MAG_W+4*g +: 4] >= ADJ_MIN) ?
			q.sh[MAG_W+4*g +: 4] + ADJ_ADD : q.sh[MAG_W+4*g +: 4];
	end

	// ======================================================
	// shift and add
	always_comb begin
		d = q;
		if (q.cnt == '0) begin
			d.sh    = {{BCD_W{1'b0}}, bin};
			d.tag_w = tag;
			d.cnt   = CNT_W'(MAG_W);
		end else begin
			d.sh  = {adj, q.sh[MAG_W-1:0]} << 1;
			d.cnt = q.cnt - 1'b1;
			if (q.cnt == CNT_W'(1)) begin
				d.bcd = d.sh[MAG_W +: BCD_W];
				d.tag = q.tag_w;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign bcd     = q.bcd;
	assign tag_out = q.tag;
endmodule
`default_nettype wire

// ---- hw/bcd_port_pkg.sv ----
// constants, types and register map of the bcd result output port
`default_nettype none
package bcd_port_pkg;
	// ======================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int DIV_W         = 17;
	localparam int MS_W          = 7;
	localparam logic [MS_W-1:0] T_SETUP_MS   = 7'h1E;
	localparam logic [MS_W-1:0] T_VALID_MS   = 7'h28;
	localparam logic [MS_W-1:0] T_RELEASE_MS = 7'h10;
	localparam logic [MS_W-1:0] T_PERIOD_MS  = 7'h40;

	// ======================================================
	// value widths
	localparam int VAL_W  = 18;
	localparam int MAG_W  = 17;
	localparam int DIGITS = 5;
	localparam int BCD_W  = 4 * DIGITS;
	localparam int CNT_W  = 5;
	localparam int TAG_W  = 2;
	localparam logic [VAL_W-1:0] MAX_MAG = 18'h1869F;
	localparam logic [3:0]       ADJ_MIN = 4'h5;
	localparam logic [3:0]       ADJ_ADD = 4'h3;

	// ======================================================
	// register map
	localparam logic [11:0] A_CTRL   = 12'h000;
	localparam logic [11:0] A_HILIM  = 12'h004;
	localparam logic [11:0] A_LOLIM  = 12'h008;
	localparam logic [11:0] A_STATUS = 12'h00C;
	localparam logic [11:0] A_RESULT = 12'h010;
	localparam int CTRL_MODE_LSB = 0;
	localparam int MODE_W        = 3;
	localparam int CTRL_CONT_BIT = 3;
	localparam int CTRL_STBY_BIT = 4;
	localparam logic [VAL_W-1:0] HILIM_RST = 18'h003E8;
	localparam logic [VAL_W-1:0] LOLIM_RST = 18'h00000;

	// ======================================================
	// types
	typedef enum logic [MODE_W-1:0] {M_NORMAL, M_SAMPLE, M_PEAK, M_BOTTOM, M_P2P} hold_mode_e;
	typedef enum logic [2:0] {P_IDLE, P_SETUP, P_VALID, P_TAIL, P_CONT} port_state_e;

	typedef struct packed {
		hold_mode_e mode;
		logic       cont;
		logic       stby;
	} ctrl_s;

	typedef struct packed {
		logic [BCD_W-1:0] data;
		logic             polarity;
		logic             over;
		logic             valid;
		logic             run;
	} bcd_out_s;

	typedef struct packed {
		logic hi;
		logic pass;
		logic lo;
	} cmp_out_s;

	typedef struct packed {
		logic [BCD_W+MAG_W-1:0] sh;
		logic [CNT_W-1:0]       cnt;
		logic [TAG_W-1:0]       tag_w;
		logic [BCD_W-1:0]       bcd;
		logic [TAG_W-1:0]       tag;
	} conv_state_s;

	typedef struct packed {
		logic [DIV_W-1:0]        ms_div;
		logic [MS_W-1:0]         ms_cnt;
		port_state_e             pst;
		logic                    req_q;
		logic                    trig_q;
		ctrl_s                   ctrl;
		logic signed [VAL_W-1:0] hilim;
		logic signed [VAL_W-1:0] lolim;
		logic signed [VAL_W-1:0] result;
		logic signed [VAL_W-1:0] pk;
		logic signed [VAL_W-1:0] bt;
		logic signed [VAL_W-1:0] run_max;
		logic signed [VAL_W-1:0] run_min;
		logic                    armed;
		bcd_out_s                out;
		cmp_out_s                cmp;
		logic                    pready;
		logic                    pslverr;
		logic [31:0]             prdata;
	} top_state_s;
endpackage
`default_nettype wire

// ---- hw/bcd_result_port.sv ----
// bcd result output port with hold modes, comparison and apb registers
//
// Contract
// - data and valid appear 30 ms after request
// - single: valid off 40 ms, data 16 ms later
// - held request: fresh result every 64 ms
// - freeze keeps old or new data, never low
// - sampling hold captures value at trigger edge
// - peak or bottom hold keeps extreme in window
// - peak-to-peak reports max minus min in window
// - normal mode updates comparison every result
// - standby holds comparison off until first pass
// - port control inputs are active low
//
// Added by the designer: register access over APB and the register addresses.
`default_nettype none
module bcd_result_port
	import bcd_port_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
)(
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// measurement source
	input  wire logic                    meas_valid,
	input  wire logic signed [VAL_W-1:0] meas,
	input  wire logic                    sample_trig,
	// port control, active low
	input  wire logic                    req_n,
	input  wire logic                    freeze_n,
	input  wire logic                    show_max_n,
	input  wire logic                    show_min_n,
	input  wire logic                    clear_n,
	// port outputs
	output bcd_out_s                     bcd_out,
	output cmp_out_s                     cmp_out
);
	top_state_s q;
	top_state_s d;

	logic                    tick;
	logic                    req_on;
	logic                    req_rise;
	logic                    trig_rise;
	logic                    reload;
	logic signed [VAL_W-1:0] sel;
	logic        [VAL_W-1:0] mag;
	logic                    in_band;
	logic        [MAG_W-1:0] conv_bin;
	logic        [BCD_W-1:0] conv_bcd;
	logic        [TAG_W-1:0] conv_tag;

	// ======================================================
	// combinational helpers
	assign tick      = (q.ms_div == DIV_W'(MS_CYCLES - 1));
	assign req_on    = !req_n;
	assign req_rise  = req_on && !q.req_q;
	assign trig_rise = sample_trig && !q.trig_q;
	assign reload    = (q.pst == P_CONT) && req_on && tick && freeze_n
		&& (q.ms_cnt == T_PERIOD_MS - 1'b1);
	assign sel = !show_max_n ? q.run_max : (!show_min_n ? q.run_min : q.result);
	assign mag = sel[VAL_W-1] ? VAL_W'(-sel) : VAL_W'(sel);
	assign in_band = (sel <= q.hilim) && (sel >= q.lolim);
	assign conv_bin = (mag > MAX_MAG) ? MAX_MAG[MAG_W-1:0] : mag[MAG_W-1:0];

	bcd_convert u_conv (
		.pclk    (pclk),
		.presetn (presetn),
		.bin     (conv_bin),
		.tag     ({sel[VAL_W-1], mag > MAX_MAG}),
		.bcd     (conv_bcd),
		.tag_out (conv_tag)
	);

	// ======================================================
	// next state
	always_comb begin
		d         = q;
		d.ms_div  = tick ? '0 : q.ms_div + 1'b1;
		d.req_q   = req_on;
		d.trig_q  = sample_trig;
		d.out.run = 1'b1;

		// hold modes
		unique case (q.ctrl.mode)
			M_NORMAL: begin
				if (meas_valid)
					d.result = meas;
			end
			M_SAMPLE: begin
				if (trig_rise)
					d.result = meas;
			end
			M_PEAK, M_BOTTOM, M_P2P: begin
				if (trig_rise) begin
					d.pk = meas;
					d.bt = meas;
				end else if (sample_trig && meas_valid) begin
					d.pk = (meas > q.pk) ? meas : q.pk;
					d.bt = (meas < q.bt) ? meas : q.bt;
				end
				if (q.ctrl.mode == M_PEAK)
					d.result = d.pk;
				else if (q.ctrl.mode == M_BOTTOM)
					d.result = d.bt;
				else
					d.result = VAL_W'(d.pk - d.bt);
			end
			default: d.result = meas;
		endcase

		// running extremes and standby arming
		if (!clear_n) begin
			d.run_max = q.result;
			d.run_min = q.result;
			d.armed   = 1'b0;
		end else begin
			if (q.result > q.run_max)
				d.run_max = q.result;
			if (q.result < q.run_min)
				d.run_min = q.result;
			d.armed = q.armed || in_band;
		end

		// comparison outputs
		if (q.ctrl.stby && !d.armed) begin
			d.cmp = '0;
		end else begin
			d.cmp.hi   = sel > q.hilim;
			d.cmp.pass = in_band;
			d.cmp.lo   = sel < q.lolim;
		end

		// port sequencer
		unique case (q.pst)
			P_IDLE: begin
				if (req_rise) begin
					d.pst    = P_SETUP;
					d.ms_cnt = '0;
				end
			end
			P_SETUP: begin
				if (tick) begin
					d.ms_cnt = q.ms_cnt + 1'b1;
					if (q.ms_cnt == T_SETUP_MS - 1'b1) begin
						d.out.data     = conv_bcd;
						d.out.polarity = conv_tag[1];
						d.out.over     = conv_tag[0];
						d.out.valid    = 1'b1;
						d.ms_cnt       = '0;
						d.pst          = (q.ctrl.cont && req_on) ? P_CONT : P_VALID;
					end
				end
			end
			P_VALID: begin
				if (tick) begin
					d.ms_cnt = q.ms_cnt + 1'b1;
					if (q.ms_cnt == T_VALID_MS - 1'b1) begin
						d.out.valid = 1'b0;
						d.ms_cnt    = '0;
						d.pst       = P_TAIL;
					end
				end
			end
			P_TAIL: begin
				if (tick) begin
					d.ms_cnt = q.ms_cnt + 1'b1;
					if (q.ms_cnt == T_RELEASE_MS - 1'b1) begin
						d.out.data     = '0;
						d.out.polarity = 1'b0;
						d.out.over     = 1'b0;
						d.pst          = P_IDLE;
					end
				end
			end
			P_CONT: begin
				if (!req_on) begin
					d.out.valid = 1'b0;
					d.ms_cnt    = '0;
					d.pst       = P_TAIL;
				end else if (tick) begin
					d.ms_cnt = q.ms_cnt + 1'b1;
					if (q.ms_cnt == T_VALID_MS - 1'b1)
						d.out.valid = 1'b0;
					if (q.ms_cnt == T_PERIOD_MS - 1'b1) begin
						d.ms_cnt    = '0;
						d.out.valid = 1'b1;
						if (reload) begin
							d.out.data     = conv_bcd;
							d.out.polarity = conv_tag[1];
							d.out.over     = conv_tag[0];
						end
					end
				end
			end
			default: d.pst = P_IDLE;
		endcase

		// apb slave, one wait state
		d.pready  = 1'b0;
		d.pslverr = 1'b0;
		if (psel && penable && !q.pready) begin
			d.pready = 1'b1;
			d.prdata = '0;
			unique case (paddr)
				A_CTRL:   d.prdata = 32'({q.ctrl.stby, q.ctrl.cont, q.ctrl.mode});
				A_HILIM:  d.prdata = 32'(q.hilim);
				A_LOLIM:  d.prdata = 32'(q.lolim);
				A_STATUS: d.prdata = 32'({q.pst, q.armed, q.out.valid});
				A_RESULT: d.prdata = 32'(q.result);
				default:  d.pslverr = 1'b1;
			endcase
		end
		// writes land at the edge where pready is seen high
		if (psel && penable && pwrite && q.pready) begin
			unique case (paddr)
				A_CTRL: begin
					d.ctrl.mode = hold_mode_e'(pwdata[CTRL_MODE_LSB +: MODE_W]);
					d.ctrl.cont = pwdata[CTRL_CONT_BIT];
					d.ctrl.stby = pwdata[CTRL_STBY_BIT];
				end
				A_HILIM: d.hilim = pwdata[VAL_W-1:0];
				A_LOLIM: d.lolim = pwdata[VAL_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q       <= '0;
			q.hilim <= HILIM_RST;
			q.lolim <= LOLIM_RST;
		end else begin
			q <= d;
		end
	end

	assign prdata  = q.prdata;
	assign pready  = q.pready;
	assign pslverr = q.pslverr;
	assign bcd_out = q.out;
	assign cmp_out = q.cmp;

	// ======================================================
	// checks
	chk_valid_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
		(q.pst == P_SETUP && tick && q.ms_cnt == T_SETUP_MS - 1'b1) |=> q.out.valid)
		else $error("valid not raised at end of setup");
	chk_valid_cause: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(q.out.valid) |-> ($past(q.pst) == P_SETUP || $past(q.pst) == P_CONT))
		else $error("valid raised outside setup or continuous");
	chk_valid_drop: assert property (@(posedge pclk) disable iff (!presetn)
		(q.pst == P_VALID && tick && q.ms_cnt == T_VALID_MS - 1'b1)
		|=> !q.out.valid && q.pst == P_TAIL)
		else $error("valid not dropped after hold time");
	chk_data_release: assert property (@(posedge pclk) disable iff (!presetn)
		(q.pst == P_TAIL && tick && q.ms_cnt == T_RELEASE_MS - 1'b1)
		|=> q.out.data == '0 && q.pst == P_IDLE)
		else $error("data not released after tail");
	chk_cont_stable: assert property (@(posedge pclk) disable iff (!presetn)
		(q.pst == P_CONT && !reload) |=> $stable(q.out.data))
		else $error("continuous data changed without reload");
	chk_single_ignore: assert property (@(posedge pclk) disable iff (!presetn)
		(q.pst == P_VALID || q.pst == P_TAIL) |=> q.pst != P_SETUP)
		else $error("request accepted during single cycle");
	chk_sample_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(q.ctrl.mode == M_SAMPLE && trig_rise) |=> q.result == $past(meas))
		else $error("sample hold missed trigger value");
	chk_peak_track: assert property (@(posedge pclk) disable iff (!presetn)
		(q.ctrl.mode == M_PEAK && sample_trig && q.trig_q && meas_valid && meas > q.pk)
		|=> q.pk == $past(meas) && q.result == q.pk)
		else $error("peak not tracked");
	chk_p2p_diff: assert property (@(posedge pclk) disable iff (!presetn)
		(q.ctrl.mode == M_P2P && $past(q.ctrl.mode) == M_P2P) |-> q.result == VAL_W'(q.pk - q.bt))
		else $error("peak to peak differs from max minus min");
	chk_normal_update: assert property (@(posedge pclk) disable iff (!presetn)
		(q.ctrl.mode == M_NORMAL && meas_valid) |=> q.result == $past(meas))
		else $error("normal mode result not updated");
	chk_standby_off: assert property (@(posedge pclk) disable iff (!presetn)
		(q.ctrl.stby && !q.armed && clear_n) |=> (q.cmp == '0 || q.armed))
		else $error("comparison active before first pass");
endmodule
`default_nettype wire

// ---- testbench/bcd_reader.sv ----
// reader model: requests a bcd result and times the strobe and data
`default_nettype none
module bcd_reader
	import bcd_port_pkg::*;
#(
	parameter int MS_CYCLES = 4
)(
	// clock
	input  wire logic     pclk,
	// port from device
	input  wire bcd_out_s bcd,
	// request to device, active low
	output var logic      req_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req_n = 1'b1;

	// ======================================================
	// request level for continuous reads
	task automatic set_req(input logic lvl);
		req_n <= lvl;
		@(posedge pclk);
	endtask

	// ======================================================
	// one single read with timing of strobe and data
	task automatic read_once(output logic [BCD_W-1:0] d, output logic [1:0] f,
		output int t_on, output int t_hi, output int t_off);
		t_on = 0;
		t_hi = 0;
		t_off = 0;
		req_n <= 1'b0;
		@(posedge pclk);
		while (bcd.valid !== 1'b1 && t_on < 200) begin
			@(posedge pclk);
			t_on++;
		end
		d = bcd.data;
		f = {bcd.polarity, bcd.over};
		req_n <= 1'b1;
		while (bcd.valid === 1'b1 && t_hi < 300) begin
			@(posedge pclk);
			t_hi++;
		end
		while (bcd.data !== '0 && t_off < 100) begin
			@(posedge pclk);
			t_off++;
		end
		repeat (20 * MS_CYCLES) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ---- testbench/test_bcd_result_output_port.sv ----
// testbench of the bcd result output port
`default_nettype none
module test_bcd_result_output_port;
	import bcd_port_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int MS = 4;
	logic                    pclk = 1'b0;
	logic                    presetn = 1'b0;
	logic                    psel = 1'b0;
	logic                    penable = 1'b0;
	logic                    pwrite = 1'b0;
	logic [11:0]             paddr = 12'h000;
	logic [31:0]             pwdata = 32'h0;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	logic                    meas_valid = 1'b0;
	logic signed [VAL_W-1:0] meas = 18'h00000;
	logic                    sample_trig = 1'b0;
	logic                    req_n;
	logic                    freeze_n = 1'b1;
	logic                    clear_n = 1'b1;
	logic                    show_max_n = 1'b1;
	logic                    show_min_n = 1'b1;
	bcd_out_s                bcd_out;
	cmp_out_s                cmp_out;
	int                      errors = 0;
	int                      checked = 0;
	int                      cyc = 0;

	bcd_result_port #(.MS_CYCLES(MS)) i_bcd_result_port (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.meas_valid(meas_valid), .meas(meas), .sample_trig(sample_trig), .req_n(req_n),
		.freeze_n(freeze_n), .show_max_n(show_max_n), .show_min_n(show_min_n),
		.clear_n(clear_n),
		.bcd_out(bcd_out), .cmp_out(cmp_out)
	);
	bcd_reader #(.MS_CYCLES(MS)) i_bcd_reader (.pclk(pclk), .bcd(bcd_out), .req_n(req_n));

	initial forever #5 pclk = ~pclk;

	// ======================================================
	// helpers
	task end_sim;
		$display("counts checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			end_sim();
		end
	end

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task rng(input string nm, input int lo, input int hi, input int v);
		checked++;
		if (v < lo || v > hi) begin
			errors++;
			$display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, v);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task put_meas(input logic signed [VAL_W-1:0] v);
		meas <= v;
		meas_valid <= 1'b1;
		@(posedge pclk);
		meas_valid <= 1'b0;
		repeat (30) @(posedge pclk);
	endtask

	task wv(input logic lvl, output int n);
		n = 0;
		while (bcd_out.valid !== lvl && n < 400) begin
			@(posedge pclk);
			n++;
		end
	endtask

	// ======================================================
	// scenarios
	task t_regs;
		logic [31:0] r;
		logic        e;
		apb(1'b0, A_CTRL, 32'h0, r, e);
		chk("ctrl reset", 32'h0, r);
		apb(1'b0, A_HILIM, 32'h0, r, e);
		chk("hilim reset", 32'h3E8, r);
		apb(1'b0, A_LOLIM, 32'h0, r, e);
		chk("lolim reset", 32'h0, r);
		apb(1'b0, A_STATUS, 32'h0, r, e);
		chk("status idle", 32'h2, r);
		chk("run level", 32'h1, {31'h0, bcd_out.run});
		apb(1'b0, 12'h020, 32'h0, r, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		apb(1'b1, A_CTRL, 32'h1C, r, e);
		apb(1'b0, A_CTRL, 32'h0, r, e);
		chk("ctrl back", 32'h1C, r);
		apb(1'b1, A_RESULT, 32'h55, r, e);
		chk("result wr err", 32'h0, {31'h0, e});
		$display("test regs done");
	endtask

	task t_single;
		logic [31:0]      r;
		logic             e;
		logic [BCD_W-1:0] d;
		logic [1:0]       f;
		int               t_on;
		int               t_hi;
		int               t_off;
		apb(1'b1, A_CTRL, 32'h0, r, e);
		put_meas(18'h004D2);
		i_bcd_reader.read_once(d, f, t_on, t_hi, t_off);
		rng("valid delay", 28 * MS, 30 * MS + 2, t_on);
		chk("single data", 32'h01234, {12'h0, d});
		chk("single flags", 32'h0, {30'h0, f});
		rng("valid width", 40 * MS - 1, 40 * MS + 1, t_hi);
		rng("data off", 16 * MS - 1, 16 * MS + 1, t_off);
		put_meas(18'h27960);
		i_bcd_reader.read_once(d, f, t_on, t_hi, t_off);
		chk("over data", 32'h99999, {12'h0, d});
		chk("over flags", 32'h3, {30'h0, f});
		rng("over width", 40 * MS - 1, 40 * MS + 1, t_hi);
		$display("test single done");
	endtask

	task t_cont;
		logic [31:0] r;
		logic        e;
		int          n1;
		int          n2;
		int          bad;
		apb(1'b1, A_CTRL, 32'h8, r, e);
		put_meas(18'h0006F);
		i_bcd_reader.set_req(1'b0);
		wv(1'b1, n1);
		chk("cont first", 32'h00111, {12'h0, bcd_out.data});
		put_meas(18'h000DE);
		wv(1'b0, n1);
		wv(1'b1, n2);
		rng("period", 64 * MS - 1, 64 * MS + 1, n1 + n2 + 31);
		chk("cont fresh", 32'h00222, {12'h0, bcd_out.data});
		freeze_n <= 1'b0;
		put_meas(18'h0014D);
		bad = 0;
		repeat (300) begin
			@(posedge pclk);
			if (bcd_out.data !== 20'h00222)
				bad++;
		end
		chk("freeze held", 32'h0, bad);
		freeze_n <= 1'b1;
		i_bcd_reader.set_req(1'b1);
		repeat (18 * MS) @(posedge pclk);
		chk("cont off", 32'h0, {12'h0, bcd_out.data});
		repeat (20 * MS) @(posedge pclk);
		$display("test continuous done");
	endtask

	task t_modes;
		logic [31:0] r;
		logic        e;
		logic [31:0] exp [5];
		exp = '{32'h14, 32'h7, 32'h9, 32'h3, 32'h6};
		for (int m = 0; m < 5; m++) begin
			apb(1'b1, A_CTRL, 32'(m), r, e);
			put_meas(18'h00007);
			sample_trig <= 1'b1;
			@(posedge pclk);
			put_meas(18'h00005);
			put_meas(18'h00009);
			put_meas(18'h00003);
			sample_trig <= 1'b0;
			put_meas(18'h00014);
			apb(1'b0, A_RESULT, 32'h0, r, e);
			chk("mode result", exp[m], r);
		end
		$display("test modes done");
	endtask

	task t_cmp;
		logic [31:0] r;
		logic        e;
		apb(1'b1, A_CTRL, 32'h0, r, e);
		put_meas(18'h007D0);
		chk("cmp high", 32'h4, {29'h0, cmp_out});
		put_meas(18'h3FFFB);
		chk("cmp low", 32'h1, {29'h0, cmp_out});
		put_meas(18'h001F4);
		chk("cmp pass", 32'h2, {29'h0, cmp_out});
		apb(1'b1, A_CTRL, 32'h10, r, e);
		put_meas(18'h007D0);
		clear_n <= 1'b0;
		@(posedge pclk);
		clear_n <= 1'b1;
		repeat (30) @(posedge pclk);
		chk("stby off", 32'h0, {29'h0, cmp_out});
		put_meas(18'h001F4);
		chk("stby pass", 32'h2, {29'h0, cmp_out});
		show_max_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("show max", 32'h4, {29'h0, cmp_out});
		show_max_n <= 1'b1;
		put_meas(18'h007D0);
		chk("stby high", 32'h4, {29'h0, cmp_out});
		show_min_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("show min", 32'h2, {29'h0, cmp_out});
		show_min_n <= 1'b1;
		$display("test compare done");
	endtask

	// ======================================================
	// main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_single();
		t_cont();
		t_modes();
		t_cmp();
		end_sim();
	end
endmodule
`default_nettype wire
